// >>> common/asfr_pkg.sv
// constants for the converter status flag register bank
// assumes a 32-bit axi4-lite slave with 8-bit byte addresses
package asfr_pkg;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned NCHAN  = 6;

    // register indices; byte address is four times the index
    localparam logic [5:0] STATUS_IDX = 6'h01;
    localparam logic [5:0] MODE_IDX   = 6'h02;
    localparam logic [5:0] EVT_IDX    = 6'h10;
    localparam logic [5:0] MASK_IDX   = 6'h11;
    localparam logic [7:0] STATUS_ADDR = {STATUS_IDX, 2'b00};
    localparam logic [7:0] MODE_ADDR   = {MODE_IDX, 2'b00};
    localparam logic [7:0] EVT_ADDR    = {EVT_IDX, 2'b00};
    localparam logic [7:0] MASK_ADDR   = {MASK_IDX, 2'b00};

    // status word and mode register fields
    localparam int unsigned LOCK_BIT   = 15;
    localparam int unsigned RESYNC_BIT = 14;
    localparam int unsigned REGMAP_BIT = 13;
    localparam int unsigned CRCERR_BIT = 12;
    localparam int unsigned CTYPE_BIT  = 11;
    localparam int unsigned RSTF_BIT   = 10;
    localparam int unsigned WLEN_LSB   = 8;
    localparam int unsigned REGCRC_BIT = 13;
    localparam int unsigned RXCRC_BIT  = 12;

    // mode register reset and writable bits (15:14 always read zero)
    localparam logic [15:0] MODE_RESET = 16'h0510;
    localparam logic [15:0] MODE_WMASK = 16'h3fff;

    // event status / mask layout
    localparam int unsigned EVT_W      = 4;
    localparam int unsigned EV_RESYNC  = 0;
    localparam int unsigned EV_REGMAP  = 1;
    localparam int unsigned EV_CRCERR  = 2;
    localparam int unsigned EV_NEWDATA = 3;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> src/asfr_status_bank.sv
// status flag word and mode register of a six-channel converter, axi4-lite slave
// assumes lock_pin is asynchronous; all pulses come from logic on aclk
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - bit 15 shows interface lock, reset unlocked
// - bit 14 set on every converter resync
// - bit 13 set when register checksum changes
// - bit 12 set on input checksum error
// - bit 11 mirrors selected checksum polynomial
// - bit 10 reads one after reset
// - bits 9:8 show word length, default 24
// - bits 5:0 new-data flag per channel
// - mode register at index 02h, reset 0510h
// - polynomial and length come from mode register
module asfr_status_bank #(
    parameter int unsigned CHANNELS = asfr_pkg::NCHAN
) (
    input  wire logic                       aclk,
    input  wire logic                       aresetn,
    input  wire logic [asfr_pkg::ADDR_W-1:0] awaddr,
    input  wire logic [2:0]                 awprot,
    input  wire logic                       awvalid,
    output var  logic                       awready,
    input  wire logic [31:0]                wdata,
    input  wire logic [3:0]                 wstrb,
    input  wire logic                       wvalid,
    output var  logic                       wready,
    output var  logic [1:0]                 bresp,
    output var  logic                       bvalid,
    input  wire logic                       bready,
    input  wire logic [asfr_pkg::ADDR_W-1:0] araddr,
    input  wire logic [2:0]                 arprot,
    input  wire logic                       arvalid,
    output var  logic                       arready,
    output var  logic [31:0]                rdata,
    output var  logic [1:0]                 rresp,
    output var  logic                       rvalid,
    input  wire logic                       rready,
    input  wire logic                       lock_pin,
    input  wire logic                       resync_pulse,
    input  wire logic                       regmap_change_pulse,
    input  wire logic                       rx_crc_error_pulse,
    input  wire logic [CHANNELS-1:0]        sample_done,
    input  wire logic [CHANNELS-1:0]        sample_taken,
    output var  logic                       irq,
    output var  logic [1:0]                 word_length_select,
    output var  logic                       crc_ansi_select,
    output var  logic                       regmap_crc_enable,
    output var  logic                       rx_crc_enable
);
    logic                       aw_hold, next_aw_hold, next_awready;
    logic [7:0]                 aw_addr, next_aw_addr;
    logic                       w_hold, next_w_hold, next_wready;
    logic [31:0]                w_data, next_w_data;
    logic [3:0]                 w_strb, next_w_strb;
    logic                       next_bvalid, next_arready, next_rvalid;
    logic [1:0]                 next_bresp, next_rresp;
    logic [31:0]                next_rdata;
    logic [15:0]                mode, next_mode;
    logic                       converter_resync_flag, next_resync;
    logic                       regmap_flag, next_regmap;
    logic                       crcerr_flag, next_crcerr;
    logic [CHANNELS-1:0]        new_sample, next_new_sample;
    logic [asfr_pkg::EVT_W-1:0] evt, next_evt, evt_mask, next_evt_mask, evt_set;
    logic                       next_irq, lock_flag;
    logic                       have_aw, have_w, do_write, rd_fire, status_rd;
    logic [7:0]                 wr_addr;
    logic [31:0]                wr_data;
    logic [3:0]                 wr_strb;
    logic [15:0]                status_word;
    logic                       rd_was_status;

    // the status word has room for six new-data flags only
    if (CHANNELS < 1 || CHANNELS > asfr_pkg::NCHAN) begin : g_bad_channels
        $error("asfr_status_bank serves one to six channels");
    end

    asfr_sync #(.WIDTH(1)) lock_sync (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .async_in (lock_pin),
        .sync_out (lock_flag)
    );

    assign word_length_select = mode[asfr_pkg::WLEN_LSB +: 2];
    assign crc_ansi_select    = mode[asfr_pkg::CTYPE_BIT];
    assign regmap_crc_enable  = mode[asfr_pkg::REGCRC_BIT];
    assign rx_crc_enable      = mode[asfr_pkg::RXCRC_BIT];

    // checksum type, reset flag and length mirror mode
    always_comb begin
        status_word = '0;
        status_word[asfr_pkg::LOCK_BIT]   = lock_flag;
        status_word[asfr_pkg::RESYNC_BIT] = converter_resync_flag;
        status_word[asfr_pkg::REGMAP_BIT] = regmap_flag;
        status_word[asfr_pkg::CRCERR_BIT] = crcerr_flag;
        status_word[asfr_pkg::CTYPE_BIT]  = mode[asfr_pkg::CTYPE_BIT];
        status_word[asfr_pkg::RSTF_BIT]   = mode[asfr_pkg::RSTF_BIT];
        status_word[asfr_pkg::WLEN_LSB +: 2] = mode[asfr_pkg::WLEN_LSB +: 2];
        status_word[CHANNELS-1:0]         = new_sample;
    end

    // bus handshakes: address and data may arrive in either order
    always_comb begin
        have_aw = aw_hold | (awvalid & awready);
        have_w  = w_hold | (wvalid & wready);
        wr_addr = aw_hold ? aw_addr : awaddr;
        wr_data = w_hold ? w_data : wdata;
        wr_strb = w_hold ? w_strb : wstrb;
        do_write = have_aw & have_w & ~bvalid;
        rd_fire  = arvalid & arready;
        status_rd = rd_fire & (araddr == asfr_pkg::STATUS_ADDR);

        next_aw_hold = have_aw & ~do_write;
        next_aw_addr = wr_addr;
        next_w_hold  = have_w & ~do_write;
        next_w_data  = wr_data;
        next_w_strb  = wr_strb;
        next_bvalid  = do_write | (bvalid & ~bready);
        next_bresp   = bresp;
        next_awready = ~next_aw_hold & ~next_bvalid;
        next_wready  = ~next_w_hold & ~next_bvalid;

        next_mode     = mode;
        next_evt_mask = evt_mask;
        if (do_write) begin
            next_bresp = asfr_pkg::RESP_OKAY;
            case (wr_addr)
                // status write accepted but has no effect
                asfr_pkg::STATUS_ADDR: begin
                end
                asfr_pkg::MODE_ADDR: begin
                    if (wr_strb[0]) begin
                        next_mode[7:0] = wr_data[7:0];
                    end
                    if (wr_strb[1]) begin
                        next_mode[15:8] = wr_data[15:8];
                    end
                    next_mode = next_mode & asfr_pkg::MODE_WMASK;
                end
                asfr_pkg::EVT_ADDR: begin
                end
                asfr_pkg::MASK_ADDR: begin
                    if (wr_strb[0]) begin
                        next_evt_mask = wr_data[asfr_pkg::EVT_W-1:0];
                    end
                end
                default: begin
                    next_bresp = asfr_pkg::RESP_SLVERR;
                end
            endcase
        end

        next_rvalid  = rd_fire | (rvalid & ~rready);
        next_arready = ~next_rvalid;
        next_rdata   = rdata;
        next_rresp   = rresp;
        if (rd_fire) begin
            next_rdata = '0;
            next_rresp = asfr_pkg::RESP_OKAY;
            case (araddr)
                asfr_pkg::STATUS_ADDR: next_rdata[15:0] = status_word;
                asfr_pkg::MODE_ADDR:   next_rdata[15:0] = mode;
                asfr_pkg::EVT_ADDR:    next_rdata[asfr_pkg::EVT_W-1:0] = evt;
                asfr_pkg::MASK_ADDR:   next_rdata[asfr_pkg::EVT_W-1:0] = evt_mask;
                default:               next_rresp = asfr_pkg::RESP_SLVERR;
            endcase
        end
    end

    // sticky flags clear on a status read; a new event in that cycle wins
    always_comb begin
        next_resync = resync_pulse | (converter_resync_flag & ~status_rd);
        next_regmap = regmap_change_pulse | (regmap_flag & ~status_rd);
        next_crcerr = rx_crc_error_pulse | (crcerr_flag & ~status_rd);
    end

    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
        assign next_new_sample[ch] = sample_done[ch] | (new_sample[ch] & ~sample_taken[ch]);
    end

    // event bits are write-one-to-clear; set beats clear
    always_comb begin
        evt_set = '0;
        evt_set[asfr_pkg::EV_RESYNC]  = resync_pulse;
        evt_set[asfr_pkg::EV_REGMAP]  = regmap_change_pulse;
        evt_set[asfr_pkg::EV_CRCERR]  = rx_crc_error_pulse;
        evt_set[asfr_pkg::EV_NEWDATA] = |sample_done;
        next_evt = evt;
        if (do_write && wr_addr == asfr_pkg::EVT_ADDR && wr_strb[0]) begin
            next_evt = evt & ~wr_data[asfr_pkg::EVT_W-1:0];
        end
        next_evt = next_evt | evt_set;
        next_irq = |(next_evt & next_evt_mask);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold <= 1'b0;
            aw_addr <= '0;
            w_hold  <= 1'b0;
            w_data  <= '0;
            w_strb  <= '0;
            awready <= 1'b0;
            wready  <= 1'b0;
            bvalid  <= 1'b0;
            bresp   <= asfr_pkg::RESP_OKAY;
            arready <= 1'b0;
            rvalid  <= 1'b0;
            rdata   <= '0;
            rresp   <= asfr_pkg::RESP_OKAY;
            mode    <= asfr_pkg::MODE_RESET;
            converter_resync_flag <= 1'b0;
            regmap_flag <= 1'b0;
            crcerr_flag <= 1'b0;
            new_sample  <= '0;
            evt         <= '0;
            evt_mask    <= '0;
            irq         <= 1'b0;
            rd_was_status <= 1'b0;
        end else begin
            aw_hold <= next_aw_hold;
            aw_addr <= next_aw_addr;
            w_hold  <= next_w_hold;
            w_data  <= next_w_data;
            w_strb  <= next_w_strb;
            awready <= next_awready;
            wready  <= next_wready;
            bvalid  <= next_bvalid;
            bresp   <= next_bresp;
            arready <= next_arready;
            rvalid  <= next_rvalid;
            rdata   <= next_rdata;
            rresp   <= next_rresp;
            mode    <= next_mode;
            converter_resync_flag <= next_resync;
            regmap_flag <= next_regmap;
            crcerr_flag <= next_crcerr;
            new_sample  <= next_new_sample;
            evt         <= next_evt;
            evt_mask    <= next_evt_mask;
            irq         <= next_irq;
            rd_was_status <= rd_fire ? (araddr == asfr_pkg::STATUS_ADDR) : rd_was_status;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_mode_wr_hi;
        do_write && wr_addr == asfr_pkg::MODE_ADDR && wr_strb[1];
    endsequence
    sequence s_read_taken;
        arvalid && arready;
    endsequence

    a_lock_follows: assert property (lock_pin [*4] |=> lock_flag)
        else $error("lock flag did not follow a steady lock pin");
    a_resync_set: assert property (resync_pulse |=> status_word[14])
        else $error("resync event did not set status bit 14");
    a_regmap_set: assert property (regmap_change_pulse ##1 !status_rd |=> status_word[13])
        else $error("checksum change flag lost");
    a_crcerr_set: assert property (rx_crc_error_pulse |=> status_word[12])
        else $error("input checksum error did not set bit 12");
    a_ctype_mirror: assert property (s_mode_wr_hi |=> status_word[11] == $past(wr_data[11]))
        else $error("checksum type bit not mirrored");
    a_rstflag_clear: assert property (s_mode_wr_hi and !wr_data[10] |=> !status_word[10])
        else $error("reset flag not cleared by writing zero");
    a_rstflag_reset: assert property ($rose(aresetn) |-> status_word[10] && mode == asfr_pkg::MODE_RESET)
        else $error("mode or reset flag wrong after reset");
    a_wlen_mirror: assert property (s_mode_wr_hi |=> status_word[9:8] == $past(wr_data[9:8]))
        else $error("word length not mirrored into status");
    a_chan_flag: assert property (sample_done[0] |=> status_word[0])
        else $error("channel 0 new-data flag not set");
    a_status_ro: assert property (s_read_taken ##1 rd_was_status |-> rdata[7:6] == 2'b00)
        else $error("reserved status bits read nonzero");
    a_irq_raise: assert property (resync_pulse && evt_mask[0] && !do_write |=> irq)
        else $error("unmasked event did not raise irq");
endmodule
`default_nettype wire

// >>> src/asfr_sync.sv
// three-stage input synchroniser with agreement filter
// assumes inputs arrive asynchronously to aclk
`timescale 1ns/10ps
`default_nettype none
module asfr_sync #(
    parameter int unsigned WIDTH = 1
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    input  wire logic [WIDTH-1:0] async_in,
    output var  logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;
    logic [WIDTH-1:0] next_sync_out;

    if (WIDTH < 1) begin : g_bad_width
        $error("asfr_sync needs WIDTH of at least one");
    end

    // a change counts only once the second and third stages agree
    always_comb begin
        for (int i = 0; i < WIDTH; i++) begin
            next_sync_out[i] = (stage2[i] == stage3[i]) ? stage3[i] : sync_out[i];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            stage1   <= '0;
            stage2   <= '0;
            stage3   <= '0;
            sync_out <= '0;
        end else begin
            stage1   <= async_in;
            stage2   <= stage1;
            stage3   <= stage2;
            sync_out <= next_sync_out;
        end
    end
endmodule
`default_nettype wire

// >>> tb/adc_status_flag_register_tb.sv
// testbench for the status flag bank: axi4-lite master tasks and checks
// assumes asfr_conv_model stands in for the converter logic
`timescale 1ns/10ps
`default_nettype none
module adc_status_flag_register_tb;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [3:0]  wstrb = 4'h0;
    logic        awready, wready, bvalid, arready, rvalid, irq, lock_pin, crc_ansi_select;
    logic        regmap_crc_enable, rx_crc_enable;
    logic [1:0]  bresp, rresp, word_length_select;
    logic [31:0] rdata;
    logic        resync_pulse, regmap_change_pulse, rx_crc_error_pulse;
    logic [5:0]  sample_done, sample_taken;
    int          error_cnt = 0;
    int          checks = 0;

    always #10 aclk = ~aclk;

    asfr_status_bank dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .lock_pin(lock_pin), .resync_pulse(resync_pulse),
        .regmap_change_pulse(regmap_change_pulse), .rx_crc_error_pulse(rx_crc_error_pulse),
        .sample_done(sample_done), .sample_taken(sample_taken), .irq(irq),
        .word_length_select(word_length_select), .crc_ansi_select(crc_ansi_select),
        .regmap_crc_enable(regmap_crc_enable), .rx_crc_enable(rx_crc_enable));

    asfr_conv_model conv (.aclk(aclk), .lock_pin(lock_pin), .resync_pulse(resync_pulse),
        .regmap_change_pulse(regmap_change_pulse), .rx_crc_error_pulse(rx_crc_error_pulse),
        .sample_done(sample_done), .sample_taken(sample_taken));

    task automatic final_report();
        $display("checks=%0d error_cnt=%0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // bounded wait; running out is a mismatch and ends the run
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) begin
                error_cnt++;
                final_report();
            end
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int n;
        n = 0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            n++;
            if (n > 50) begin
                error_cnt++;
                final_report();
            end
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b0;
        chk(rdata, ed);
        chk({30'h0, rresp}, {30'h0, er});
    endtask

    localparam logic [1:0] OK = asfr_pkg::RESP_OKAY;
    localparam logic [1:0] SE = asfr_pkg::RESP_SLVERR;
    localparam logic [7:0] ST = asfr_pkg::STATUS_ADDR;
    localparam logic [7:0] MD = asfr_pkg::MODE_ADDR;

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({30'h0, word_length_select}, 32'h0000_0001);
        rd(ST, 32'h0000_0500, OK);
        rd(MD, 32'h0000_0510, OK);
        wr(ST, 32'h0000_ffff, 4'hf, OK);
        rd(ST, 32'h0000_0500, OK);
        // sticky flags show once, cleared by the read
        for (int k = 0; k < 3; k++) begin
            conv.pulse(3'(1 << k), 6'h00, 6'h00);
            rd(ST, 32'h0000_0500 | (32'h0000_4000 >> k), OK);
            rd(ST, 32'h0000_0500, OK);
        end
        conv.set_lock(1'b1);
        rd(ST, 32'h0000_8500, OK);
        conv.set_lock(1'b0);
        rd(ST, 32'h0000_0500, OK);
        for (int n = 0; n < 6; n++) begin
            conv.pulse(3'h0, 6'(1 << n), 6'h00);
            rd(ST, 32'h0000_0500 | (32'h1 << n), OK);
            conv.pulse(3'h0, 6'h00, 6'(1 << n));
            rd(ST, 32'h0000_0500, OK);
        end
        // every word length code, polynomial toggled alongside
        for (int i = 0; i < 4; i++) begin
            wr(MD, 32'h0000_0410 | (i << 8) | ((i & 1) << 11), 4'hf, OK);
            rd(ST, 32'h0000_0400 | (i << 8) | ((i & 1) << 11), OK);
            chk({30'h0, word_length_select}, i);
            chk({31'h0, crc_ansi_select}, i & 1);
        end
        wr(MD, 32'h0000_01f0, 4'hf, OK);
        rd(ST, 32'h0000_0100, OK);
        rd(MD, 32'h0000_01f0, OK);
        wr(MD, 32'h0000_0510, 4'hf, OK);
        wr(MD, 32'h0000_0000, 4'h1, OK);
        rd(MD, 32'h0000_0500, OK);
        rd(asfr_pkg::EVT_ADDR, 32'h0000_000f, OK);
        wr(asfr_pkg::EVT_ADDR, 32'h0000_000f, 4'hf, OK);
        rd(asfr_pkg::EVT_ADDR, 32'h0000_0000, OK);
        // irq follows only unmasked events
        wr(asfr_pkg::MASK_ADDR, 32'h0000_0001, 4'hf, OK);
        conv.pulse(3'h2, 6'h00, 6'h00);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        conv.pulse(3'h1, 6'h00, 6'h00);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0001);
        wr(asfr_pkg::EVT_ADDR, 32'h0000_0001, 4'hf, OK);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        rd(8'h80, 32'h0000_0000, SE);
        wr(8'h80, 32'h0000_ffff, 4'hf, SE);
        wr(8'h09, 32'h0000_0000, 4'hf, SE);
        rd(MD, 32'h0000_0500, OK);
        // bits 15:14 of mode stay zero; enables reach their outputs
        wr(MD, 32'h0000_ffff, 4'h3, OK);
        rd(MD, 32'h0000_3fff, OK);
        wr(MD, 32'h0000_3100, 4'hf, OK);
        chk({31'h0, regmap_crc_enable}, 32'h0000_0001);
        chk({31'h0, rx_crc_enable}, 32'h0000_0001);
        // resync and checksum-change flags from the irq pulses are still unread
        rd(ST, 32'h0000_6100, OK);
        wr(asfr_pkg::MASK_ADDR, 32'h0000_0002, 4'hf, OK);
        chk({31'h0, irq}, 32'h0000_0001);
        // reset in mid-run brings the reset flag back and drops irq
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        chk({31'h0, irq}, 32'h0000_0000);
        chk({30'h0, rx_crc_enable, regmap_crc_enable}, 32'h0000_0000);
        rd(ST, 32'h0000_0500, OK);
        rd(MD, 32'h0000_0510, OK);
        final_report();
    end
endmodule
`default_nettype wire

// >>> tb/asfr_conv_model.sv
// converter-side model: lock level and one-cycle event pulses on aclk
// assumes the testbench calls its tasks from one process only
`timescale 1ns/10ps
`default_nettype none
module asfr_conv_model (
    input  wire logic       aclk,
    output var  logic       lock_pin,
    output var  logic       resync_pulse,
    output var  logic       regmap_change_pulse,
    output var  logic       rx_crc_error_pulse,
    output var  logic [5:0] sample_done,
    output var  logic [5:0] sample_taken
);
    initial begin
        lock_pin = 1'b0;
        resync_pulse = 1'b0;
        regmap_change_pulse = 1'b0;
        rx_crc_error_pulse = 1'b0;
        sample_done = 6'h00;
        sample_taken = 6'h00;
    end

    task automatic pulse(input logic [2:0] ev, input logic [5:0] done, input logic [5:0] taken);
        @(posedge aclk);
        resync_pulse        <= ev[0];
        regmap_change_pulse <= ev[1];
        rx_crc_error_pulse  <= ev[2];
        sample_done         <= done;
        sample_taken        <= taken;
        @(posedge aclk);
        resync_pulse        <= 1'b0;
        regmap_change_pulse <= 1'b0;
        rx_crc_error_pulse  <= 1'b0;
        sample_done         <= 6'h00;
        sample_taken        <= 6'h00;
    endtask

    // lock is a level; wait out the synchroniser
    task automatic set_lock(input logic v);
        @(posedge aclk);
        lock_pin <= v;
        repeat (8) @(posedge aclk);
    endtask
endmodule
`default_nettype wire
